// *** hw/route_tone_pkg.sv ***
// Constants, types and register map of the audio routing and tone control block.
// How it works
// R1: Code 03 drives both SCART outputs with de-emphasized mono from channel one.
// R2: The recorder line output always carries the loudspeaker output's source.
// R3: Host must not write unused code 4A; the block mutes everything for it.
// R4: Treble and bass each take a 4-bit word selecting one of fourteen steps.
// R5: One treble and one bass setting serve both loudspeaker channels alike.
// R6: Auxiliary attenuator is on only for bass steps eleven to fourteen.
// R7: Left and right attenuators share one bass step decode.
// R8: Attenuation is 2.5, 5, 7.5 or 10 dB for bass steps 11 to 14.
// R9: Host should raise loudspeaker volume when the attenuator is switched on.
// R10: Dual and mono codes use channel one as first language, ident 10 or 00.
// R11: Routing code sits at subaddress 06 and resets to code 00.
// R12: Treble and bass share subaddress 05, resetting to flat value 88.
// R13: Remaining code bits decode into output sources and an identification code.
// R14: The two don't-care code bits are ignored by the routing decode.
package route_tone_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] TONE_IDX = 8'h05;
	localparam logic [7:0] ROUTE_IDX = 8'h06;
	localparam logic [7:0] STATUS_IDX = 8'h08;
	localparam logic [7:0] TONE_RESET = 8'h88;
	localparam logic [6:0] ROUTE_RESET = 7'h00;
	localparam int BASS_LSB = 4;
	localparam int TREBLE_LSB = 0;
	localparam int CODE_B_BIT = 6;
	localparam int STAT_IDENT_LSB = 0;
	localparam int STAT_IDENT_VALID_BIT = 2;
	localparam int STAT_ATT_EN_BIT = 3;
	localparam int STAT_ATT_LEVEL_LSB = 4;

	// ------------------------------------------------------------
	// Tone steps
	// ------------------------------------------------------------
	localparam logic [3:0] STEP_MIN = 4'h1;
	localparam logic [3:0] STEP_MAX = 4'hE;
	localparam logic [3:0] ATT_FIRST_STEP = 4'hB;
	localparam logic [3:0] ATT_STEP_BASE = 4'hA;

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_NONE = 2'h0,
		SEL_TONE = 2'h1,
		SEL_ROUTE = 2'h2,
		SEL_STATUS = 2'h3
	} reg_sel_t;

	// Source feeding a left/right output pair.
	typedef enum logic [2:0] {
		PR_MUTE = 3'h0,
		PR_DEM = 3'h1,
		PR_SCART = 3'h2,
		PR_CH1 = 3'h3,
		PR_CH2 = 3'h4,
		PR_SPLIT = 3'h5,
		PR_DEEMPH_MONO = 3'h6,
		PR_AM = 3'h7
	} pair_t;

	typedef struct packed {
		pair_t loudspeaker_output;
		pair_t headphone_output;
		pair_t recorder_line_output;
		pair_t scart_output;
		logic [1:0] ident_code;
		logic ident_valid;
	} route_t;

	typedef struct packed {
		logic [3:0] treble;
		logic [3:0] bass;
		logic att_left_en;
		logic att_right_en;
		logic [2:0] att_level;
	} tone_t;

	localparam logic [1:0] ID_STEREO = 2'h1;
	localparam logic [1:0] ID_DUAL = 2'h2;
	localparam logic [1:0] ID_MONO = 2'h0;

endpackage

// *** hw/route_decode.sv ***
// Selection code to output source and identification decode.
`timescale 1ns/1ps
module route_decode (
	input wire logic [6:0] code,
	output route_tone_pkg::route_t route
);

	function automatic route_tone_pkg::route_t row(
		input route_tone_pkg::pair_t ls,
		input route_tone_pkg::pair_t hp,
		input route_tone_pkg::pair_t sc,
		input logic [1:0] id,
		input logic idv
	);
		route_tone_pkg::route_t r;
		r.loudspeaker_output = ls;
		r.headphone_output = hp;
		// R2 recorder_line_output copies loudspeaker
		r.recorder_line_output = ls;
		r.scart_output = sc;
		r.ident_code = id;
		r.ident_valid = idv;
		return r;
	endfunction

	logic [4:0] key;

	// R14 drop don't-care bits
	assign key = {code[route_tone_pkg::CODE_B_BIT], code[3:0]};

	// R13 full routing table
	always_comb begin
		unique case (key)
			// R1 mono to SCART
			5'h03: route = row(route_tone_pkg::PR_DEM, route_tone_pkg::PR_DEM,
				route_tone_pkg::PR_DEEMPH_MONO, route_tone_pkg::ID_STEREO, 1'b1);
			5'h04: route = row(route_tone_pkg::PR_DEM, route_tone_pkg::PR_DEM,
				route_tone_pkg::PR_DEM, route_tone_pkg::ID_STEREO, 1'b1);
			5'h00: route = row(route_tone_pkg::PR_SCART, route_tone_pkg::PR_SCART,
				route_tone_pkg::PR_DEM, route_tone_pkg::ID_STEREO, 1'b1);
			5'h10: route = row(route_tone_pkg::PR_CH1, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_DEM, route_tone_pkg::ID_STEREO, 1'b1);
			5'h02: route = row(route_tone_pkg::PR_CH1, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_DEM, route_tone_pkg::ID_STEREO, 1'b1);
			5'h01: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_DEM, route_tone_pkg::ID_STEREO, 1'b1);
			5'h11: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_DEM, route_tone_pkg::ID_STEREO, 1'b1);
			// R10 channel one is first language or mono
			5'h14, 5'h16: route = row(route_tone_pkg::PR_CH1, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_SPLIT, route_tone_pkg::ID_DUAL, 1'b1);
			5'h06, 5'h0A: route = row(route_tone_pkg::PR_CH1, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_SPLIT, route_tone_pkg::ID_DUAL, 1'b1);
			5'h05, 5'h09: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_SPLIT, route_tone_pkg::ID_DUAL, 1'b1);
			5'h15, 5'h17: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_SPLIT, route_tone_pkg::ID_DUAL, 1'b1);
			5'h0F, 5'h12: route = row(route_tone_pkg::PR_CH1, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_CH1, route_tone_pkg::ID_MONO, 1'b1);
			5'h07: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_CH2, route_tone_pkg::ID_DUAL, 1'b1);
			5'h0B: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_CH2, route_tone_pkg::ID_DUAL, 1'b1);
			5'h08: route = row(route_tone_pkg::PR_SCART, route_tone_pkg::PR_SCART,
				route_tone_pkg::PR_SPLIT, route_tone_pkg::ID_DUAL, 1'b1);
			5'h0C: route = row(route_tone_pkg::PR_SCART, route_tone_pkg::PR_SCART,
				route_tone_pkg::PR_CH1, route_tone_pkg::ID_MONO, 1'b1);
			5'h1B: route = row(route_tone_pkg::PR_SCART, route_tone_pkg::PR_SCART,
				route_tone_pkg::PR_CH2, route_tone_pkg::ID_MONO, 1'b1);
			5'h0E: route = row(route_tone_pkg::PR_CH1, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_CH1, route_tone_pkg::ID_MONO, 1'b1);
			5'h0D: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_CH1, route_tone_pkg::ID_MONO, 1'b1);
			5'h13: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_CH1, route_tone_pkg::ID_MONO, 1'b1);
			5'h1C: route = row(route_tone_pkg::PR_SCART, route_tone_pkg::PR_SCART,
				route_tone_pkg::PR_AM, route_tone_pkg::ID_MONO, 1'b0);
			5'h18: route = row(route_tone_pkg::PR_CH1, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_AM, route_tone_pkg::ID_MONO, 1'b0);
			5'h1E: route = row(route_tone_pkg::PR_CH1, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_AM, route_tone_pkg::ID_MONO, 1'b0);
			5'h1D: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH1,
				route_tone_pkg::PR_AM, route_tone_pkg::ID_MONO, 1'b0);
			5'h19: route = row(route_tone_pkg::PR_CH2, route_tone_pkg::PR_CH2,
				route_tone_pkg::PR_AM, route_tone_pkg::ID_MONO, 1'b0);
			5'h1F: route = row(route_tone_pkg::PR_AM, route_tone_pkg::PR_AM,
				route_tone_pkg::PR_AM, route_tone_pkg::ID_MONO, 1'b0);
			// R3 unused code mutes every output
			default: route = row(route_tone_pkg::PR_MUTE, route_tone_pkg::PR_MUTE,
				route_tone_pkg::PR_MUTE, route_tone_pkg::ID_MONO, 1'b0);
		endcase
	end

endmodule

// *** hw/route_tone_ctrl.sv ***
// AXI4-Lite register file with routing and tone control decode.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module route_tone_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output route_tone_pkg::route_t route_out,
	output route_tone_pkg::tone_t tone_out
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic route_tone_pkg::reg_sel_t decode_addr(input logic [7:0] a);
		if (a == {route_tone_pkg::TONE_IDX[5:0], 2'h0}) begin
			return route_tone_pkg::SEL_TONE;
		end else if (a == {route_tone_pkg::ROUTE_IDX[5:0], 2'h0}) begin
			return route_tone_pkg::SEL_ROUTE;
		end else if (a == {route_tone_pkg::STATUS_IDX[5:0], 2'h0}) begin
			return route_tone_pkg::SEL_STATUS;
		end
		return route_tone_pkg::SEL_NONE;
	endfunction

	// Out-of-range words are clamped so a bad write still lands on a real step.
	function automatic logic [3:0] clamp_step(input logic [3:0] w);
		if (w < route_tone_pkg::STEP_MIN) begin
			return route_tone_pkg::STEP_MIN;
		end else if (w > route_tone_pkg::STEP_MAX) begin
			return route_tone_pkg::STEP_MAX;
		end
		return w;
	endfunction

	// ------------------------------------------------------------
	// Registers and bus state
	// ------------------------------------------------------------
	logic [7:0] tone_r, tone_nxt;
	logic [6:0] route_code_r, route_code_nxt;
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic [7:0] w_byte_r, w_byte_nxt;
	logic w_en_r, w_en_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	route_tone_pkg::route_t route_r, route_nxt, route_dec;
	route_tone_pkg::tone_t tone_out_r, tone_out_nxt;
	route_tone_pkg::reg_sel_t wsel, rsel;
	logic do_write;

	route_decode u_decode (
		.code(route_code_r),
		.route(route_dec)
	);

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	always_comb begin
		aw_hold_nxt = aw_hold_r;
		aw_addr_nxt = aw_addr_r;
		w_hold_nxt = w_hold_r;
		w_byte_nxt = w_byte_r;
		w_en_nxt = w_en_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		tone_nxt = tone_r;
		route_code_nxt = route_code_r;
		wsel = decode_addr(aw_addr_r);
		rsel = decode_addr(s_axi_araddr);
		do_write = aw_hold_r && w_hold_r && !bvalid_r;
		if (s_axi_awvalid && awready_r) begin
			aw_hold_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_hold_nxt = 1'b1;
			w_byte_nxt = s_axi_wdata[7:0];
			w_en_nxt = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (do_write) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (wsel == route_tone_pkg::SEL_NONE) ?
				route_tone_pkg::RESP_DECERR : route_tone_pkg::RESP_OKAY;
			// R4 4-bit treble and bass words
			if (w_en_r && wsel == route_tone_pkg::SEL_TONE) begin
				tone_nxt = w_byte_r;
			end
			// R11 routing code register
			if (w_en_r && wsel == route_tone_pkg::SEL_ROUTE) begin
				route_code_nxt = w_byte_r[6:0];
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = route_tone_pkg::RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			unique case (rsel)
				route_tone_pkg::SEL_TONE: rdata_nxt[7:0] = tone_r;
				route_tone_pkg::SEL_ROUTE: rdata_nxt[6:0] = route_code_r;
				route_tone_pkg::SEL_STATUS: begin
					rdata_nxt[route_tone_pkg::STAT_IDENT_LSB +: 2] = route_r.ident_code;
					rdata_nxt[route_tone_pkg::STAT_IDENT_VALID_BIT] = route_r.ident_valid;
					rdata_nxt[route_tone_pkg::STAT_ATT_EN_BIT] = tone_out_r.att_left_en;
					rdata_nxt[route_tone_pkg::STAT_ATT_LEVEL_LSB +: 3] = tone_out_r.att_level;
				end
				route_tone_pkg::SEL_NONE: rresp_nxt = route_tone_pkg::RESP_DECERR;
			endcase
		end
		awready_nxt = !aw_hold_nxt;
		wready_nxt = !w_hold_nxt;
		arready_nxt = !rvalid_nxt;
	end

	// ------------------------------------------------------------
	// Output decode
	// ------------------------------------------------------------
	always_comb begin
		route_nxt = route_dec;
		// R5 one setting for both channels
		tone_out_nxt.treble = clamp_step(tone_r[route_tone_pkg::TREBLE_LSB +: 4]);
		tone_out_nxt.bass = clamp_step(tone_r[route_tone_pkg::BASS_LSB +: 4]);
		// R6 attenuator only on top four bass steps
		tone_out_nxt.att_left_en = tone_out_nxt.bass >= route_tone_pkg::ATT_FIRST_STEP;
		// R7 both sides share the decode
		tone_out_nxt.att_right_en = tone_out_nxt.att_left_en;
		// R8 level counts 2.5 dB units
		tone_out_nxt.att_level = tone_out_nxt.att_left_en ?
			3'(tone_out_nxt.bass - route_tone_pkg::ATT_STEP_BASE) : 3'h0;
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// R12 flat tone after reset
			tone_r <= route_tone_pkg::TONE_RESET;
			route_code_r <= route_tone_pkg::ROUTE_RESET;
			aw_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_hold_r <= 1'b0;
			w_byte_r <= 8'h00;
			w_en_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= 2'h0;
			rdata_r <= 32'h0000_0000;
			route_r <= '0;
			tone_out_r <= '0;
		end else if (ce) begin
			tone_r <= tone_nxt;
			route_code_r <= route_code_nxt;
			aw_hold_r <= aw_hold_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_hold_r <= w_hold_nxt;
			w_byte_r <= w_byte_nxt;
			w_en_r <= w_en_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			route_r <= route_nxt;
			tone_out_r <= tone_out_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign route_out = route_r;
	assign tone_out = tone_out_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// R1 mono on SCART
	mono_scart_a: assert property (ce && route_code_r[6] == 1'b0 && route_code_r[3:0] == 4'h3 |=> // R1
		route_out.scart_output == route_tone_pkg::PR_DEEMPH_MONO) else $error("code 03 scart wrong");
	// R2 recorder_line_output follows loudspeaker
	recorder_line_output_follows_a: assert property (route_out.recorder_line_output == // R2
		route_out.loudspeaker_output) else $error("recorder_line_output differs from loudspeaker");
	// R6 attenuator enable
	att_enable_a: assert property (ce |=> tone_out.att_left_en == // R6
		($past(tone_r[7:4]) >= 4'hB && $past(tone_r[7:4]) != 4'hF || $past(tone_r[7:4]) == 4'hF))
		else $error("attenuator enable wrong");
	// R7 shared attenuator
	att_pair_a: assert property (tone_out.att_left_en == tone_out.att_right_en) // R7
		else $error("attenuators disagree");
	// R8 attenuation level
	att_level_a: assert property (tone_out.att_left_en |-> // R8
		tone_out.att_level == 3'(tone_out.bass - 4'hA) && tone_out.att_level != 3'h0)
		else $error("attenuation level wrong");
	// R10 dual ident
	dual_ident_a: assert property (ce && route_code_r == 7'h44 |=> // R10
		route_out.ident_code == 2'h2 && route_out.loudspeaker_output == route_tone_pkg::PR_CH1)
		else $error("dual ident wrong");
	// R11 routing write lands
	route_write_a: assert property (ce && do_write && w_en_r && aw_addr_r == 8'h18 |=> // R11
		route_code_r == $past(w_byte_r[6:0]) && s_axi_bvalid) else $error("route write lost");
	// R12 tone write lands
	tone_write_a: assert property (ce && do_write && w_en_r && aw_addr_r == 8'h14 |=> // R12
		tone_r == $past(w_byte_r)) else $error("tone write lost");
	// R14 don't-care bits
	// The outputs leave their reset value one edge after release, so that edge is excluded.
	dont_care_a: assert property (ce && $stable(route_code_r[6]) && $stable(route_code_r[3:0]) // R14
		&& $past(ce) && $past(aresetn) |=> $stable(route_out))
		else $error("dont care bits changed routing");
	write_resp_a: assert property (ce && do_write |=> s_axi_bvalid) // R11
		else $error("no write response");

	cov_write_c: cover property (s_axi_bvalid && s_axi_bready);
	cov_read_c: cover property (s_axi_rvalid && s_axi_rready);
	cov_att_c: cover property (tone_out.att_level == 3'h4);
	cov_am_c: cover property (route_out.scart_output == route_tone_pkg::PR_AM);

endmodule

// *** bench/host_axil_model.sv ***
// AXI4-Lite host master model that drives the register bus of the control block.
`timescale 1ns/1ps
module host_axil_model (
	input wire logic aclk,
	output logic awvalid,
	input wire logic awready,
	output logic [7:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	output logic arvalid,
	input wire logic arready,
	output logic [7:0] araddr,
	input wire logic rvalid,
	output logic rready
);
	// Cycles the host lets pass before it accepts an answer.
	int stall;

	initial begin
		stall = 0;
		{awvalid, awaddr, wvalid, wdata, wstrb, bready} = '0;
		{arvalid, araddr, rready} = '0;
	end

	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	// no unused code: callers never pass routing code 4A here.
	// volume compensation: there is no volume register here, so it is left to the system.
	// Released lines show the inverse of the last value, so stale data never looks valid.
	task automatic write_word(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic aw_done;
		logic w_done;
		logic b_done;
		n = 0;
		{aw_done, w_done, b_done} = 3'h0;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		bready <= (stall == 0);
		while (!b_done) begin
			@(posedge aclk);
			n++;
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid && bready) begin
				b_done = 1'b1;
			end else if (n >= stall) begin
				bready <= 1'b1;
			end
		end
		bready <= 1'b0;
	endtask

	task automatic read_word(input logic [7:0] a);
		int n;
		logic ar_done;
		logic r_done;
		n = 0;
		{ar_done, r_done} = 2'h0;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= (stall == 0);
		while (!r_done) begin
			@(posedge aclk);
			n++;
			if (!ar_done && arready) begin
				ar_done = 1'b1;
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid && rready) begin
				r_done = 1'b1;
			end else if (n >= stall) begin
				rready <= 1'b1;
			end
		end
		rready <= 1'b0;
	endtask
endmodule

// *** bench/audio_routing_tone_control_tb_top.sv ***
// Self-checking testbench of the routing and tone control block.
`timescale 1ns/1ps
module audio_routing_tone_control_tb_top;
	logic aclk;
	logic aresetn;
	logic ce;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	route_tone_pkg::route_t route;
	route_tone_pkg::tone_t tone;
	logic [33:0] exp_q[$];
	logic [33:0] note;
	logic [18:0] rt [0:8];
	logic [31:0] seed;
	logic [3:0] cb, ct, lvl;
	logic en;
	int err_count = 0;
	int compares = 0;
	int cycles = 0;

	route_tone_ctrl uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .route_out(route), .tone_out(tone));

	host_axil_model host (.aclk(aclk), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		host.write_word(a, d, s);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, d});
		host.read_word(a);
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	function automatic logic [3:0] clamp(input logic [3:0] v);
		return (v == 4'h0) ? 4'h1 : ((v == 4'hF) ? 4'hE : v);
	endfunction

	// Answers are matched in order against the oldest note.
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			give_verdict();
		end
		if ((rvalid && rready) || (bvalid && bready)) begin
			if (exp_q.size() == 0) begin
				check("queue", 34'h1, 34'h0);
			end else begin
				note = exp_q.pop_front();
				if (rvalid && rready) begin
					check("rdata", {rresp, rdata}, note);
				end else begin
					check("bresp", {bresp, 32'h0}, note);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		// Code, loudspeaker, headphone, scart, ident, ident valid.
		rt[0] = {7'h04, 3'h1, 3'h1, 3'h1, 2'h1, 1'h1};
		rt[1] = {7'h34, 3'h1, 3'h1, 3'h1, 2'h1, 1'h1};
		rt[2] = {7'h03, 3'h1, 3'h1, 3'h6, 2'h1, 1'h1};
		rt[3] = {7'h44, 3'h3, 3'h3, 3'h5, 2'h2, 1'h1};
		rt[4] = {7'h05, 3'h4, 3'h3, 3'h5, 2'h2, 1'h1};
		rt[5] = {7'h07, 3'h4, 3'h4, 3'h4, 2'h2, 1'h1};
		rt[6] = {7'h0F, 3'h3, 3'h3, 3'h3, 2'h0, 1'h1};
		rt[7] = {7'h77, 3'h4, 3'h4, 3'h5, 2'h2, 1'h1};
		rt[8] = {7'h4F, 3'h7, 3'h7, 3'h7, 2'h0, 1'h0};
		ce = 1'b1;
		aresetn = 1'b0;
		seed = 32'hDAF754A6;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		#1;
		check("ident", {route.ident_valid, route.ident_code}, 34'h5);
		rd(8'h14, 32'h88, 2'h0);
		rd(8'h18, 32'h0, 2'h0);
		rd(8'h10, 32'h0, 2'h3);
		wr(8'h30, 32'h4F, 4'hF, 2'h3);
		wr(8'h18, 32'h4F, 4'hE, 2'h0);
		wr(8'h20, 32'hFF, 4'hF, 2'h0);
		rd(8'h18, 32'h0, 2'h0);
		rd(8'h20, 32'h5, 2'h0);
		$display("reset and map test done");
		for (int b = 0; b < 16; b++) begin
			seed = xs(seed);
			host.stall = seed[9:8];
			wr(8'h14, {seed[31:8], b[3:0], seed[3:0]}, {seed[7:5], 1'b1}, 2'h0);
			repeat (2) @(posedge aclk);
			#1;
			cb = clamp(b[3:0]);
			ct = clamp(seed[3:0]);
			en = (cb >= 4'hB);
			lvl = en ? cb - 4'hA : 4'h0;
			check("bass", tone.bass, cb);
			check("treble", tone.treble, ct);
			check("att_l", tone.att_left_en, en);
			check("att_r", tone.att_right_en, en);
			check("att_lvl", tone.att_level, lvl);
			rd(8'h20, {25'h0, lvl[2:0], en, 3'h5}, 2'h0);
		end
		wr(8'h14, 32'h88, 4'h1, 2'h0);
		$display("tone test done");
		for (int i = 0; i < 9; i++) begin
			seed = xs(seed);
			host.stall = seed[1:0];
			wr(8'h18, {25'h0, rt[i][18:12]}, 4'hF, 2'h0);
			repeat (2) @(posedge aclk);
			#1;
			check("ls", route.loudspeaker_output, rt[i][11:9]);
			check("recorder_line_output", route.recorder_line_output, rt[i][11:9]);
			check("hp", route.headphone_output, rt[i][8:6]);
			check("scart", route.scart_output, rt[i][5:3]);
			check("idv", route.ident_valid, rt[i][0]);
			if (rt[i][0]) begin
				check("ident", route.ident_code, rt[i][2:1]);
				rd(8'h20, {29'h0, rt[i][0], rt[i][2:1]}, 2'h0);
			end
		end
		$display("routing test done");
		repeat (4) @(posedge aclk);
		check("pending", exp_q.size(), 34'h0);
		give_verdict();
	end
endmodule
